// [dcc_pkg.sv]
package dcc_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int NCH = 4;
  localparam int CW = 2;

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0] OFF_CRC_CTRL = 8'h00;
  localparam logic [7:0] OFF_CRC_DATA = 8'h04;
  localparam logic [7:0] OFF_CRC_TAPS = 8'h08;
  localparam logic [7:0] OFF_BLK_LEN = 8'h0C;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFF_CHAN_BASE = 8'h20;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CC_IP_MODE = 15;
  localparam int CC_POLY_LENGTH_LO = 8;
  localparam int CC_CRC_EN = 7;
  localparam int CH_ACTIVE = 15;
  localparam int CH_CHAIN_DIR = 8;
  localparam int CH_ON = 7;
  localparam int CH_EVT_OFF = 6;
  localparam int CH_CHAIN_OK = 5;
  localparam int CH_REARM = 4;
  localparam int CH_SEEN = 2;
  localparam int IRQ_ABORT_LO = 4;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [4:0] RST_POLY_LENGTH = 5'h1F;
  localparam logic [15:0] RST_BLK_LEN = 16'h0001;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic chain_direction_select;
    logic chan_on;
    logic events_when_off;
    logic chain_allow;
    logic auto_rearm;
    logic event_seen_flag;
    logic [1:0] chan_priority_level;
  } dcc_chan_cfg_t;

  typedef struct packed {
    logic crc_type_select;
    logic [4:0] poly_length;
    logic crc_en;
    logic [CW-1:0] crc_chan;
  } dcc_crc_cfg_t;

  typedef enum logic [1:0] {
    DCC_IDLE = 2'b01,
    DCC_XFER = 2'b10
  } dcc_state_t;

  // Ones for bit positions 0..pl
  function automatic logic [31:0] dcc_len_mask(input logic [4:0] pl);
    logic [32:0] m;
    m = (33'h0_0000_0001 << ({1'b0, pl} + 6'h01)) - 33'h0_0000_0001;
    return m[31:0];
  endfunction

endpackage

// [dcc_crc_engine.sv]
module dcc_crc_engine
  import dcc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire dcc_crc_cfg_t cfg,
  input wire logic [31:0] taps,
  input wire logic seed_we,
  input wire logic [31:0] seed,
  input wire logic feed,
  input wire logic [31:0] din,
  output logic [31:0] crc_view
);

  logic [31:0] state_reg;
  logic [31:0] state_next;

  // Stage 0 takes the feedback; stage i the previous stage, XORed where tapped
  function automatic logic [31:0] lfsr_word(input logic [31:0] s, input logic [31:0] d,
                                           input logic [31:0] t, input logic [4:0] pl);
    logic [31:0] c;
    logic fb;
    c = s;
    for (int b = 31; b >= 0; b--) begin
      fb = c[pl] ^ d[b];
      c = {c[30:0], 1'b0} ^ ({32{fb}} & t); // see RULE_05
      c[0] = fb;
    end
    return c & dcc_len_mask(pl);
  endfunction

  function automatic logic [15:0] ones_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'h0000, s[16]};
  endfunction

  always_comb begin
    state_next = state_reg;
    if (seed_we) begin
      if (cfg.crc_type_select) begin
        state_next = {16'h0000, ~seed[15:0]}; // see RULE_04
      end else begin
        state_next = seed & dcc_len_mask(cfg.poly_length); // see RULE_01
      end
    end else if (feed) begin
      if (cfg.crc_type_select) begin
        // Taps are not consulted here
        state_next = {16'h0000, ones_add(ones_add(state_reg[15:0], din[31:16]), din[15:0])}; // see RULE_06
      end else begin
        state_next = lfsr_word(state_reg, din, taps, cfg.poly_length);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= RST_WORD;
    end else begin
      state_reg <= state_next;
    end
  end

  always_comb begin
    if (cfg.crc_type_select) begin
      crc_view = {16'h0000, ~state_reg[15:0]}; // see RULE_03
    end else begin
      crc_view = state_reg & dcc_len_mask(cfg.poly_length); // see RULE_02
    end
  end

endmodule

// [dcc_arbiter.sv]
module dcc_arbiter
  import dcc_pkg::*;
(
  input wire logic [NCH-1:0] req,
  input wire logic [2*NCH-1:0] prio,
  output logic grant_valid,
  output logic [CW-1:0] grant_idx
);

  logic [1:0] best;

  // Downward scan with >= keeps the lowest index among equal levels
  always_comb begin
    grant_valid = 1'b0;
    grant_idx = '0;
    best = 2'b00;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (req[i] && (!grant_valid || prio[2*i +: 2] >= best)) begin // see RULE_15 RULE_16
        grant_valid = 1'b1;
        grant_idx = CW'(i);
        best = prio[2*i +: 2];
      end
    end
  end

endmodule

// [dcc_dma_ctrl.sv]
// What this block does
// RULE_01: Writing CRC value seeds the generator; reading returns current CRC.
// RULE_02: In LFSR mode, CRC bits above polynomial length read zero.
// RULE_03: In IP checksum mode, only low 16 CRC bits hold data.
// RULE_04: IP mode converts written value to one's complement; reads return it.
// RULE_05: Each set tap bit enables XOR feedback at that stage.
// RULE_06: In IP mode the tap mask has no effect.
// RULE_07: Channel active flag reads one while enabled or still transferring.
// RULE_08: Chain direction picks higher-numbered or lower-numbered neighbour as trigger.
// RULE_09: Chain direction ignored unless chain allow is set.
// RULE_10: Only chain-allowed channels get enabled by neighbour completion.
// RULE_11: Clearing enable suspends after current word; software polls active flag.
// RULE_12: Events-when-off decides if start/abort events count while disabled.
// RULE_13: Auto re-arm keeps enable after block end; else hardware clears it.
// RULE_14: Event seen flag set by hardware when channel event detected.
// RULE_15: Two-bit priority, code 11 highest; arbitration uses it.
// RULE_16: Equal priority favours the lower-numbered channel.
// RULE_17: Polynomial length comes from CRC control, up to 32 bits.
module dcc_dma_ctrl
  import dcc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NCH-1:0] start_evt,
  input wire logic [NCH-1:0] abort_evt,
  output logic xfer_valid,
  output logic [CW-1:0] xfer_chan,
  input wire logic xfer_ack,
  input wire logic [31:0] xfer_data,
  output logic irq
);

  // ************************************************************
  // Storage
  // ************************************************************
  dcc_chan_cfg_t ch_reg [NCH];
  logic [NCH-1:0] pending_reg;
  logic [15:0] word_cnt_reg [NCH];
  dcc_crc_cfg_t crc_cfg_reg;
  logic [31:0] taps_reg;
  logic [15:0] blk_len_reg;
  logic [2*NCH-1:0] irq_stat_reg;
  logic [2*NCH-1:0] irq_mask_reg;
  dcc_state_t state_reg;
  logic [CW-1:0] cur_reg;
  logic xfer_valid_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic irq_reg;

  // ************************************************************
  // Bus decode
  // ************************************************************
  logic wr_go;
  logic setup;
  logic chan_hit;
  logic [CW-1:0] chan_sel;
  logic [31:0] crc_view;
  logic [31:0] rdata_next;
  logic addr_ok;

  assign wr_go = psel && penable && pwrite && pready_reg;
  assign setup = psel && !penable;
  assign chan_hit = (paddr[7:4] == OFF_CHAN_BASE[7:4]) && (paddr[1:0] == 2'b00);
  assign chan_sel = paddr[3:2];

  function automatic logic reg_wr(input logic go, input logic [7:0] a, input logic [7:0] off);
    return go && (a == off);
  endfunction

  // ************************************************************
  // Channel events
  // ************************************************************
  logic [NCH-1:0] evt_ok;
  logic [NCH-1:0] start_take;
  logic [NCH-1:0] abort_take;
  logic [NCH-1:0] req;
  logic [NCH-1:0] done_now;
  logic [NCH-1:0] chain_hit;
  logic [NCH-1:0] active;
  logic [2*NCH-1:0] prio_vec;
  logic grant_valid;
  logic [CW-1:0] grant_idx;
  logic blk_last;
  logic [15:0] cur_cnt;

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      evt_ok[i] = ch_reg[i].chan_on || ch_reg[i].events_when_off; // see RULE_12
      start_take[i] = start_evt[i] && evt_ok[i];
      abort_take[i] = abort_evt[i] && evt_ok[i];
      req[i] = pending_reg[i] && ch_reg[i].chan_on && !abort_take[i];
      prio_vec[2*i +: 2] = ch_reg[i].chan_priority_level;
      active[i] = ch_reg[i].chan_on || (state_reg == DCC_XFER && cur_reg == CW'(i)); // see RULE_07
    end
  end

  assign cur_cnt = word_cnt_reg[cur_reg];
  // A zero length still moves one word
  assign blk_last = (cur_cnt + 16'h0001) >= blk_len_reg;

  always_comb begin
    done_now = '0;
    if (state_reg == DCC_XFER && xfer_ack && blk_last && !abort_take[cur_reg]) begin
      done_now[cur_reg] = 1'b1;
    end
  end

  // Lower index is higher natural priority
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      chain_hit[i] = 1'b0;
      if (ch_reg[i].chain_allow) begin // see RULE_09 RULE_10
        if (ch_reg[i].chain_direction_select) begin
          chain_hit[i] = (i < NCH - 1) ? done_now[(i + 1) % NCH] : 1'b0; // see RULE_08
        end else begin
          chain_hit[i] = (i > 0) ? done_now[(i + NCH - 1) % NCH] : 1'b0; // see RULE_08
        end
      end
    end
  end

  dcc_arbiter u_arb (
    .req(req),
    .prio(prio_vec),
    .grant_valid(grant_valid),
    .grant_idx(grant_idx)
  );

  // ************************************************************
  // Transfer sequencer
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= DCC_IDLE;
      cur_reg <= '0;
      xfer_valid_reg <= 1'b0;
    end else begin
      case (state_reg)
        DCC_IDLE: begin
          if (grant_valid) begin
            state_reg <= DCC_XFER;
            cur_reg <= grant_idx;
            xfer_valid_reg <= 1'b1;
          end
        end
        DCC_XFER: begin
          // Disable alone waits for the word in flight to finish
          if (abort_take[cur_reg] || (xfer_ack && (blk_last || !ch_reg[cur_reg].chan_on))) begin // see RULE_11
            state_reg <= DCC_IDLE;
            xfer_valid_reg <= 1'b0;
          end
        end
        default: begin
          state_reg <= DCC_IDLE;
          xfer_valid_reg <= 1'b0;
        end
      endcase
    end
  end

  // Counts survive a suspend so the block resumes where it stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCH; i++) begin
        word_cnt_reg[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (abort_take[i] || done_now[i]) begin
          word_cnt_reg[i] <= 16'h0000;
        end else if (state_reg == DCC_XFER && cur_reg == CW'(i) && xfer_ack) begin
          word_cnt_reg[i] <= word_cnt_reg[i] + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_reg <= '0;
    end else begin
      pending_reg <= (pending_reg & ~done_now & ~abort_take) | (start_take & ~abort_take);
    end
  end

  // ************************************************************
  // Channel control
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCH; i++) begin
        ch_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (wr_go && chan_hit && chan_sel == CW'(i)) begin
          ch_reg[i].chain_direction_select <= pwdata[CH_CHAIN_DIR];
          ch_reg[i].chan_on <= pwdata[CH_ON];
          ch_reg[i].events_when_off <= pwdata[CH_EVT_OFF];
          ch_reg[i].chain_allow <= pwdata[CH_CHAIN_OK];
          ch_reg[i].auto_rearm <= pwdata[CH_REARM];
          ch_reg[i].chan_priority_level <= pwdata[1:0];
          ch_reg[i].event_seen_flag <= 1'b0;
        end
        if (done_now[i] && !ch_reg[i].auto_rearm) begin
          ch_reg[i].chan_on <= 1'b0; // see RULE_13
        end
        if (chain_hit[i]) begin
          ch_reg[i].chan_on <= 1'b1; // see RULE_08 RULE_10
        end
        // Detection beats a clearing write
        if (start_take[i] || abort_take[i]) begin
          ch_reg[i].event_seen_flag <= 1'b1; // see RULE_14
        end
      end
    end
  end

  // ************************************************************
  // CRC
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_cfg_reg <= '{crc_type_select: 1'b0, poly_length: RST_POLY_LENGTH, crc_en: 1'b0, crc_chan: '0};
      taps_reg <= RST_WORD;
      blk_len_reg <= RST_BLK_LEN;
    end else begin
      if (reg_wr(wr_go, paddr, OFF_CRC_CTRL)) begin
        crc_cfg_reg.crc_type_select <= pwdata[CC_IP_MODE];
        crc_cfg_reg.poly_length <= pwdata[CC_POLY_LENGTH_LO +: 5]; // see RULE_17
        crc_cfg_reg.crc_en <= pwdata[CC_CRC_EN];
        crc_cfg_reg.crc_chan <= pwdata[CW-1:0];
      end
      if (reg_wr(wr_go, paddr, OFF_CRC_TAPS)) begin
        taps_reg <= pwdata;
      end
      if (reg_wr(wr_go, paddr, OFF_BLK_LEN)) begin
        blk_len_reg <= pwdata[15:0];
      end
    end
  end

  dcc_crc_engine u_crc (
    .pclk(pclk),
    .presetn(presetn),
    .cfg(crc_cfg_reg),
    .taps(taps_reg),
    .seed_we(reg_wr(wr_go, paddr, OFF_CRC_DATA)), // see RULE_01
    .seed(pwdata),
    .feed(crc_cfg_reg.crc_en && state_reg == DCC_XFER && cur_reg == crc_cfg_reg.crc_chan && xfer_ack),
    .din(xfer_data),
    .crc_view(crc_view)
  );

  // ************************************************************
  // Interrupts
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~(reg_wr(wr_go, paddr, OFF_IRQ_STAT) ? pwdata[2*NCH-1:0] : '0))
                      | {abort_take, done_now};
      if (reg_wr(wr_go, paddr, OFF_IRQ_MASK)) begin
        irq_mask_reg <= pwdata[2*NCH-1:0];
      end
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  always_comb begin
    rdata_next = RST_WORD;
    addr_ok = 1'b1;
    if (chan_hit) begin
      rdata_next[CH_ACTIVE] = active[chan_sel];
      rdata_next[CH_CHAIN_DIR] = ch_reg[chan_sel].chain_direction_select;
      rdata_next[CH_ON] = ch_reg[chan_sel].chan_on;
      rdata_next[CH_EVT_OFF] = ch_reg[chan_sel].events_when_off;
      rdata_next[CH_CHAIN_OK] = ch_reg[chan_sel].chain_allow;
      rdata_next[CH_REARM] = ch_reg[chan_sel].auto_rearm;
      rdata_next[CH_SEEN] = ch_reg[chan_sel].event_seen_flag;
      rdata_next[1:0] = ch_reg[chan_sel].chan_priority_level;
    end else begin
      case (paddr)
        OFF_CRC_CTRL: begin
          rdata_next[CC_IP_MODE] = crc_cfg_reg.crc_type_select;
          rdata_next[CC_POLY_LENGTH_LO +: 5] = crc_cfg_reg.poly_length;
          rdata_next[CC_CRC_EN] = crc_cfg_reg.crc_en;
          rdata_next[CW-1:0] = crc_cfg_reg.crc_chan;
        end
        OFF_CRC_DATA: rdata_next = crc_view; // see RULE_01 RULE_02 RULE_03
        OFF_CRC_TAPS: rdata_next = taps_reg;
        OFF_BLK_LEN: rdata_next[15:0] = blk_len_reg;
        OFF_IRQ_STAT: rdata_next[2*NCH-1:0] = irq_stat_reg;
        OFF_IRQ_MASK: rdata_next[2*NCH-1:0] = irq_mask_reg;
        default: addr_ok = 1'b0;
      endcase
    end
  end

  // One wait-free access phase; data latched at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= RST_WORD;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup;
      if (setup) begin
        prdata_reg <= pwrite ? RST_WORD : rdata_next;
        pslverr_reg <= !addr_ok;
      end else begin
        // Read data shows only in the access cycle; the bus is quiet otherwise
        prdata_reg <= RST_WORD;
        pslverr_reg <= 1'b0;
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign xfer_valid = xfer_valid_reg;
  assign xfer_chan = cur_reg;
  assign irq = irq_reg;

endmodule

// [dcc_dma_ctrl_props.sv]
module dcc_dma_ctrl_props
  import dcc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NCH-1:0] abort_evt,
  input wire logic xfer_valid,
  input wire logic [CW-1:0] xfer_chan,
  input wire logic xfer_ack,
  input wire logic irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic ip_reg, mz_reg, wr, rd, mapped;
  logic [4:0] pl_reg;
  logic [3:0] dead_reg, dead_q;
  logic [32:0] lm;
  assign wr = psel && penable && pready && pwrite;
  assign rd = psel && penable && pready && !pwrite;
  assign mapped = paddr[1:0] == 2'h0 && (paddr <= OFF_IRQ_MASK || paddr[7:4] == 4'h2);
  assign lm = (33'h0_0000_0001 << ({1'b0, pl_reg} + 6'h01)) - 33'h0_0000_0001;
  // Dead means no way to start: off, events ignored, not chainable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ip_reg <= 1'b0;
      pl_reg <= RST_POLY_LENGTH;
      mz_reg <= 1'b1;
      dead_reg <= 4'hF;
      dead_q <= 4'hF;
    end else begin
      dead_q <= dead_reg;
      if (wr && paddr == OFF_CRC_CTRL) begin
        ip_reg <= pwdata[CC_IP_MODE];
        pl_reg <= pwdata[12:8];
      end
      if (wr && paddr == OFF_IRQ_MASK) begin
        mz_reg <= pwdata == 32'h0;
      end
      if (wr && paddr[7:4] == 4'h2) begin
        dead_reg[paddr[3:2]] <= pwdata[7:5] == 3'h0;
      end
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_crc_rd;
    rd && paddr == OFF_CRC_DATA;
  endsequence
  property p_ready_once; s_setup |=> pready ##1 !pready; endproperty
  a_ready_once: assert property (p_ready_once) else $error("pready not one access cycle");
  property p_slverr; pready |-> pslverr == !mapped; endproperty
  a_slverr: assert property (p_slverr) else $error("pslverr wrong for address");
  property p_idle; !rd |-> prdata == 32'h0 && (pready || !pslverr); endproperty
  a_idle: assert property (p_idle) else $error("read bus not quiet");
  property p_lfsr_mask; s_crc_rd and !ip_reg |-> (prdata & ~lm[31:0]) == 32'h0; endproperty
  a_lfsr_mask: assert property (p_lfsr_mask) else $error("crc bits above length");
  property p_ip_upper; s_crc_rd and ip_reg |-> prdata[31:16] == 16'h0; endproperty
  a_ip_upper: assert property (p_ip_upper) else $error("checksum upper half set");
  property p_busy; rd && paddr[7:4] == 4'h2 && $past(xfer_valid) && $past(xfer_chan) == paddr[3:2] |-> prdata[CH_ACTIVE]; endproperty
  a_busy: assert property (p_busy) else $error("active flag low while serving");
  property p_hold; xfer_valid && !xfer_ack && !abort_evt[xfer_chan] |=> xfer_valid && $stable(xfer_chan); endproperty
  a_hold: assert property (p_hold) else $error("word request dropped early");
  property p_dead; $rose(xfer_valid) |-> !dead_q[xfer_chan]; endproperty
  a_dead: assert property (p_dead) else $error("disabled channel served");
  property p_irq_mask; mz_reg && $past(mz_reg) |-> !irq; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq with mask clear");
endmodule

bind dcc_dma_ctrl dcc_dma_ctrl_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .abort_evt, .xfer_valid, .xfer_chan, .xfer_ack, .irq);

// [dcc_far_model.sv]
module dcc_far_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic xfer_valid,
  input wire logic [3:0] stall,
  input wire logic [31:0] word,
  output logic xfer_ack,
  output logic [31:0] xfer_data
);
  logic [3:0] wait_reg;
  logic [31:0] noise_reg;
  // Data churns off-ack so a stale word never matches by luck
  assign xfer_data = xfer_ack ? word : noise_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      noise_reg <= 32'h0;
    end else begin
      noise_reg <= noise_reg + 32'h9E37_79B9;
    end
  end
  // Still takes the word in flight after a suspend
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_ack <= 1'b0;
      wait_reg <= 4'h0;
    end else if (xfer_ack || !xfer_valid) begin
      xfer_ack <= 1'b0;
      wait_reg <= 4'h0;
    end else if (wait_reg == stall) begin
      xfer_ack <= 1'b1;
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule

// [dcc_dma_ctrl_tb.sv]
module dcc_dma_ctrl_tb
  import dcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, word = 32'h0;
  logic [NCH-1:0] start_evt = 4'h0, abort_evt = 4'h0;
  logic [3:0] stall = 4'h0;
  logic [31:0] prdata, xfer_data, rdv, exp, t, s;
  logic [4:0] pl;
  logic [CW-1:0] xfer_chan;
  logic pready, pslverr, xfer_valid, xfer_ack, irq, lerr;
  int error_cnt = 0, check_count = 0, cyc = 0;
  integer seed = 32'h4DA1;
  logic [5:0] ptab [5] = '{6'h0E, 6'h31, 6'h25, 6'h1A, 6'h29};
  dcc_dma_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .start_evt, .abort_evt, .xfer_valid, .xfer_chan, .xfer_ack, .xfer_data, .irq);
  dcc_far_model u_far (.pclk, .presetn, .xfer_valid, .stall, .word, .xfer_ack, .xfer_data);
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // ************************************************************
  // Bus, event and check tasks
  // ************************************************************
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (e !== g) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdv = prdata;
    lerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rdv);
  endtask
  task automatic ev(input logic [3:0] st, input logic [3:0] ab);
    start_evt <= st;
    abort_evt <= ab;
    @(posedge pclk);
    start_evt <= 4'h0;
    abort_evt <= 4'h0;
    @(posedge pclk);
  endtask
  // Quiet for four cycles counts as all blocks finished
  task automatic wait_idle;
    int q;
    q = 0;
    while (q < 4) begin
      @(posedge pclk);
      q = xfer_valid ? 0 : q + 1;
    end
  endtask
  task automatic xfer(input logic [3:0] m);
    ev(m, 4'h0);
    wait_idle();
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] x, input logic [31:0] tp, input logic [4:0] p,
    input logic [31:0] d);
    logic [31:0] m;
    logic fb;
    m = 32'hFFFF_FFFF >> (5'h1F - p);
    for (int b = 31; b >= 0; b--) begin
      fb = x[p] ^ d[b];
      x = ((x << 1) ^ (tp & {32{fb}})) & m;
      x[0] = fb;
    end
    return x;
  endfunction
  function automatic logic [15:0] ipsum(input logic [15:0] a, input logic [31:0] d);
    logic [16:0] x;
    x = {1'b0, a} + {1'b0, d[31:16]};
    x = {1'b0, x[15:0]} + {16'h0, x[16]};
    x = {1'b0, x[15:0]} + {1'b0, d[15:0]};
    x = {1'b0, x[15:0]} + {16'h0, x[16]};
    return x[15:0];
  endfunction
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk("crc_control", OFF_CRC_CTRL, 32'h0000_1F00);
    rchk("blk_len", OFF_BLK_LEN, 32'h0000_0001);
    rchk("chan_ctrl", OFF_CHAN_BASE, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk("slverr", 32'h1, {31'h0, lerr});
    for (int i = 0; i < 6; i++) begin
      pl = (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : 5'($random(seed));
      s = $random(seed);
      wr(OFF_CRC_CTRL, {19'h0, pl, 8'h00});
      wr(OFF_CRC_DATA, s);
      rchk("crc_seed", OFF_CRC_DATA, s & (32'hFFFF_FFFF >> (5'h1F - pl)));
    end
    wr(OFF_CRC_CTRL, 32'h0000_8000);
    s = $random(seed);
    wr(OFF_CRC_DATA, s);
    rchk("ip_seed", OFF_CRC_DATA, {16'h0, s[15:0]});
    wr(OFF_IRQ_MASK, 32'h1);
    for (int m = 0; m < 3; m++) begin
      pl = 5'($random(seed));
      t = (m == 2) ? ~t : $random(seed);
      s = $random(seed);
      word <= $random(seed);
      wr(OFF_CRC_TAPS, t);
      wr(OFF_CRC_CTRL, (m == 0) ? {19'h0, pl, 8'h80} : 32'h0000_8080);
      wr(OFF_CRC_DATA, s);
      wr(OFF_CHAN_BASE, 32'h80);
      chk("irq_low", 32'h0, {31'h0, irq});
      xfer(4'h1);
      exp = (m == 0) ? lfsr(s, t, pl, word) : {16'h0, ~ipsum(~s[15:0], word)};
      rchk("crc_result", OFF_CRC_DATA, exp);
      rchk("chan0_done", OFF_CHAN_BASE, 32'h4);
      chk("irq_high", 32'h1, {31'h0, irq});
      wr(OFF_IRQ_STAT, 32'h1);
    end
    wr(OFF_CHAN_BASE, 32'h90);
    xfer(4'h1);
    rchk("rearm", OFF_CHAN_BASE, 32'h8094);
    for (int e = 0; e < 2; e++) begin
      wr(OFF_CHAN_BASE + 8'h4, e ? 32'h40 : 32'h0);
      ev(4'h2, 4'h0);
      ev(4'h0, 4'h2);
      rchk("events_off", OFF_CHAN_BASE + 8'h4, e ? 32'h44 : 32'h0);
    end
    wr(OFF_CHAN_BASE + 8'h4, 32'h20);
    wr(OFF_CHAN_BASE + 8'h8, 32'h100);
    wr(OFF_CHAN_BASE, 32'h80);
    xfer(4'h1);
    rchk("chain_up", OFF_CHAN_BASE + 8'h4, 32'h80A0);
    wr(OFF_CHAN_BASE + 8'hC, 32'h80);
    xfer(4'h8);
    rchk("chain_off", OFF_CHAN_BASE + 8'h8, 32'h100);
    wr(OFF_CHAN_BASE + 8'h8, 32'h120);
    wr(OFF_CHAN_BASE + 8'hC, 32'h80);
    xfer(4'h8);
    rchk("chain_down", OFF_CHAN_BASE + 8'h8, 32'h81A0);
    for (int k = 0; k < 5; k++) begin
      wr(OFF_CHAN_BASE + 8'h4, {24'h0, 6'h20, ptab[k][5:4]});
      wr(OFF_CHAN_BASE + 8'h8, {24'h0, 6'h20, ptab[k][3:2]});
      ev(4'h6, 4'h0);
      @(posedge pclk);
      chk("grant", {29'h0, 1'b1, ptab[k][1:0]}, {29'h0, xfer_valid, xfer_chan});
      wait_idle();
    end
    wr(OFF_IRQ_MASK, 32'h0);
    wr(OFF_IRQ_STAT, 32'hFF);
    wr(OFF_CHAN_BASE, 32'h80);
    xfer(4'h1);
    chk("irq_masked", 32'h0, {31'h0, irq});
    rchk("irq_stat", OFF_IRQ_STAT, 32'h1);
    wr(OFF_IRQ_MASK, 32'h1);
    @(posedge pclk);
    chk("irq_unmasked", 32'h1, {31'h0, irq});
    wr(OFF_BLK_LEN, 32'h4);
    stall <= 4'hF;
    wr(OFF_CHAN_BASE, 32'h80);
    ev(4'h1, 4'h0);
    while (xfer_valid !== 1'b1) @(posedge pclk);
    wr(OFF_CHAN_BASE, 32'h0);
    rchk("suspending", OFF_CHAN_BASE, 32'h8000);
    wait_idle();
    rchk("suspended", OFF_CHAN_BASE, 32'h0);
    report_and_stop();
  end
endmodule
